/* File: core/mac_loopback_pkg.sv */
package mac_loopback_pkg;

  localparam int CLK_MHZ = 40;
  localparam int PREAMBLE_BITS = 56;
  localparam int SYNC_BITS = 8;
  localparam int PREAMBLE_BYTES = PREAMBLE_BITS / 8;
  localparam int PTR_ADVANCE_CLKS = 4;
  localparam int FIFO_HALF_DEPTH = 8;
  localparam int FIFO_DEPTH = 2 * FIFO_HALF_DEPTH;
  localparam int CRC_BYTES = 4;
  localparam int DEST_ADDR_BYTES = 6;

  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SYNC_BYTE = 8'hd5;
  localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY_REV = 32'hedb8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;

  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_PAGE = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_COMMAND = 4'h4;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h5;
  localparam logic [3:0] ADDR_RX_STATUS = 4'h6;
  localparam logic [3:0] ADDR_FIFO = 4'h7;
  localparam logic [3:0] ADDR_LINK = 4'h8;

  localparam int CFG_CRC_INHIBIT_BIT = 0;
  localparam int CFG_LOOP_LOW_BIT = 1;
  localparam int CFG_LOOP_HIGH_BIT = 2;
  localparam int CMD_TRANSMIT_BIT = 2;
  localparam int ISR_SENT_BIT = 1;
  localparam int RSR_INTACT_BIT = 0;
  localparam int RSR_CRC_ERR_BIT = 1;
  localparam int RSR_MULTICAST_BIT = 5;

  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [1:0] LOOP_NONE = 2'b00;
  localparam logic [1:0] LOOP_SERIAL = 2'b01;
  localparam logic [1:0] LOOP_CODEC = 2'b10;
  localparam logic [1:0] LOOP_EXTERNAL = 2'b11;
  localparam logic [3:0] DMA_THRESHOLD = 4'h4;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic req;
  } mem_req_t;

endpackage : mac_loopback_pkg

/* File: core/mac_loopback_diagnostics.sv */
// How it works
// R1: loopback splits fifo into tx/rx halves
// R2: memory fetched one byte per transfer
// R3: memory grants fast or packet short
// R4: rx half keeps last eight bytes
// R5: word mode: one lane, count doubled
// R6: select 01 loops serializer to deserializer
// R7: select 10 raises codec loop control
// R8: select 11 goes out over cable
// R9: link fail disables twisted-pair transmitter
// R10: codec collision and carrier masked
// R11: software returns to normal between modes
// R12: fifo read pointer advances within four clocks
// R13: host reads fifo only in loopback
// R14: rx bytes stored from zero, wrapping
// R15: count low, high, high appended
// R16: alignment follows packet length
// R17: dma fills fifo below threshold
// R18: 56-bit preamble then 8-bit sync
// R19: crc appended unless inhibited
// R20: packet sent flag at tx end
// R21: rx waits sync, counts each byte
// R22: crc checked, or forced error if matched
// R23: rx status updated, intact set
`timescale 1ns/1ps
`default_nettype none
module mac_loopback_diagnostics
  import mac_loopback_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire reg_req_t bus_req,
  output logic [7:0] bus_rdata,
  output mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] ser_tx_data,
  output logic ser_tx_valid,
  input wire logic [7:0] line_rx_data,
  input wire logic line_rx_valid,
  input wire logic line_rx_end,
  input wire logic codec_collision,
  input wire logic codec_carrier,
  input wire logic link_fail,
  input wire logic [47:0] station_addr,
  output logic codec_loop_control,
  output logic cable_tx_enable,
  output logic collision_seen,
  output logic carrier_seen
);

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_PRE = 5'b00010,
    TX_DATA = 5'b00100,
    TX_CRC = 5'b01000,
    TX_DONE = 5'b10000
  } tx_state_t;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REV) : (r >> 1);
    return r;
  endfunction : crc_step

  logic [7:0] config_q, page_q, cnt_lo_q, cnt_hi_q, isr_q, rsr_q;
  logic link_ok_q;
  // two arrays, one writer each: rx half below, tx half beside it
  logic [7:0] fifo_q [FIFO_HALF_DEPTH]; // see R1
  logic [7:0] tx_mem_q [FIFO_HALF_DEPTH]; // see R1
  logic [1:0] loop_sel;
  logic loop_on, crc_inhibit;
  assign loop_sel = {config_q[CFG_LOOP_HIGH_BIT], config_q[CFG_LOOP_LOW_BIT]};
  assign loop_on = loop_sel != LOOP_NONE;
  assign crc_inhibit = config_q[CFG_CRC_INHIBIT_BIT];

  // tx side: its half of the fifo is a ring of eight bytes
  tx_state_t tx_q;
  logic [15:0] tx_left_q, fetch_addr_q;
  logic [2:0] tx_wr_q, tx_rd_q;
  logic [3:0] tx_level_q;
  logic [2:0] pre_cnt_q;
  logic [1:0] crc_idx_q;
  logic [31:0] tx_crc_q;
  logic burst_q, fetch_pending_q;
  logic start_tx;
  assign start_tx = bus_req.wr && bus_req.addr == ADDR_COMMAND && bus_req.wdata[CMD_TRANSMIT_BIT]
                    && tx_q == TX_IDLE;

  logic pop, push;
  assign push = fetch_pending_q && mem_ack;
  assign pop = tx_q == TX_DATA && tx_level_q != 4'h0;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      config_q <= CONFIG_RESET;
      page_q <= 8'h00;
      cnt_lo_q <= 8'h00;
      cnt_hi_q <= 8'h00;
      link_ok_q <= 1'b0;
    end
    else if (bus_req.wr)
    begin
      case (bus_req.addr)
        ADDR_CONFIG: config_q <= bus_req.wdata;
        ADDR_PAGE: page_q <= bus_req.wdata;
        ADDR_COUNT_LOW: cnt_lo_q <= bus_req.wdata;
        ADDR_COUNT_HIGH: cnt_hi_q <= bus_req.wdata;
        default: ;
      endcase
      link_ok_q <= !link_fail;
    end
    else
      link_ok_q <= !link_fail;
  end

  // dma: byte-wide fetches only, bursts refill below the threshold
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tx_left_q <= 16'h0000;
      fetch_addr_q <= 16'h0000;
      burst_q <= 1'b0;
      fetch_pending_q <= 1'b0;
      tx_wr_q <= 3'h0;
    end
    else if (start_tx)
    begin
      tx_left_q <= {cnt_hi_q, cnt_lo_q};
      fetch_addr_q <= {page_q, 8'h00};
      burst_q <= 1'b1;
      fetch_pending_q <= 1'b0;
      tx_wr_q <= 3'h0;
    end
    else
    begin
      if (!burst_q && tx_left_q != 16'h0000 && tx_level_q < DMA_THRESHOLD)
        burst_q <= 1'b1; // see R17
      if (push)
      begin
        fetch_pending_q <= 1'b0;
        tx_wr_q <= tx_wr_q + 3'h1;
        tx_left_q <= tx_left_q - 16'h0001; // see R17
        fetch_addr_q <= fetch_addr_q + 16'h0001; // see R2
        if (tx_level_q == 4'(FIFO_HALF_DEPTH - 1) || tx_left_q == 16'h0001)
          burst_q <= 1'b0;
      end
      else if (burst_q && !fetch_pending_q && tx_left_q != 16'h0000
               && tx_level_q != 4'(FIFO_HALF_DEPTH))
        fetch_pending_q <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      tx_mem_q[tx_wr_q] <= mem_rdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      tx_level_q <= 4'h0;
    else if (start_tx)
      tx_level_q <= 4'h0;
    else if (push && !pop)
      tx_level_q <= tx_level_q + 4'h1;
    else if (pop && !push)
      tx_level_q <= tx_level_q - 4'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      mem_req <= '0;
    end
    else
    begin
      mem_req.req <= fetch_pending_q && !push;
      mem_req.addr <= fetch_addr_q;
    end
  end

  // transmitter
  logic tx_byte_valid;
  logic [7:0] tx_byte;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      tx_q <= TX_IDLE;
      pre_cnt_q <= 3'h0;
      crc_idx_q <= 2'h0;
      tx_crc_q <= CRC_INIT;
      tx_rd_q <= 3'h0;
      tx_byte <= 8'h00;
      tx_byte_valid <= 1'b0;
    end
    else
    begin
      tx_byte_valid <= 1'b0;
      case (tx_q)
        TX_IDLE:
        begin
          if (start_tx)
          begin
            tx_q <= TX_PRE;
            pre_cnt_q <= 3'h0;
            tx_rd_q <= 3'h0;
            tx_crc_q <= CRC_INIT;
          end
        end
        TX_PRE:
        begin
          tx_byte_valid <= 1'b1;
          if (pre_cnt_q == 3'(PREAMBLE_BYTES))
          begin
            tx_byte <= SYNC_BYTE; // see R18
            tx_q <= TX_DATA;
          end
          else
          begin
            tx_byte <= PREAMBLE_BYTE; // see R18
            pre_cnt_q <= pre_cnt_q + 3'h1;
          end
        end
        TX_DATA:
        begin
          if (pop)
          begin
            tx_byte <= tx_mem_q[tx_rd_q];
            tx_byte_valid <= 1'b1;
            tx_rd_q <= tx_rd_q + 3'h1;
            tx_crc_q <= crc_step(tx_crc_q, tx_mem_q[tx_rd_q]);
          end
          else if (tx_left_q == 16'h0000 && !fetch_pending_q)
          begin
            crc_idx_q <= 2'h0;
            tx_q <= crc_inhibit ? TX_DONE : TX_CRC; // see R19
          end
        end
        TX_CRC:
        begin
          tx_byte <= ~tx_crc_q[8*crc_idx_q +: 8]; // see R19
          tx_byte_valid <= 1'b1;
          crc_idx_q <= crc_idx_q + 2'h1;
          if (crc_idx_q == 2'(CRC_BYTES - 1))
            tx_q <= TX_DONE;
        end
        TX_DONE:
          tx_q <= TX_IDLE;
        default:
          tx_q <= TX_IDLE;
      endcase
    end
  end

  logic tx_allowed;
  assign tx_allowed = !(link_fail && !link_ok_q); // see R9
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ser_tx_data <= 8'h00;
      ser_tx_valid <= 1'b0;
      codec_loop_control <= 1'b0;
      cable_tx_enable <= 1'b0;
      collision_seen <= 1'b0;
      carrier_seen <= 1'b0;
    end
    else
    begin
      ser_tx_data <= tx_byte;
      ser_tx_valid <= tx_byte_valid && loop_sel != LOOP_SERIAL && tx_allowed; // see R6
      codec_loop_control <= loop_sel == LOOP_CODEC; // see R7
      cable_tx_enable <= (loop_sel == LOOP_EXTERNAL || !loop_on) && !link_fail; // see R8
      collision_seen <= codec_collision && !loop_on; // see R10
      carrier_seen <= codec_carrier && !loop_on; // see R10
    end
  end

  // receive path: internal serializer or the line
  logic rx_valid, rx_end;
  logic [7:0] rx_data;
  logic tx_end_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
      tx_end_q <= 1'b0;
    else
      tx_end_q <= tx_q == TX_DONE;
  end
  assign rx_valid = loop_sel == LOOP_SERIAL ? tx_byte_valid : line_rx_valid; // see R6
  assign rx_data = loop_sel == LOOP_SERIAL ? tx_byte : line_rx_data;
  assign rx_end = loop_sel == LOOP_SERIAL ? tx_end_q : line_rx_end;

  logic synced_q;
  logic [15:0] rx_count_q;
  logic [2:0] rx_wr_q;
  logic [1:0] tail_q;
  logic [31:0] rx_crc_q;
  logic [47:0] dest_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      synced_q <= 1'b0;
      rx_count_q <= 16'h0000;
      rx_wr_q <= 3'h0;
      tail_q <= 2'h0;
      rx_crc_q <= CRC_INIT;
      dest_q <= 48'h0;
    end
    else if (start_tx)
    begin
      synced_q <= 1'b0;
      rx_count_q <= 16'h0000;
      rx_wr_q <= 3'h0; // see R14
      rx_crc_q <= CRC_INIT;
    end
    else if (rx_end && synced_q && loop_on)
    begin
      synced_q <= 1'b0;
      tail_q <= 2'h3;
    end
    else if (tail_q != 2'h0)
    begin
      // lower, upper, upper again
      case (tail_q)
        2'h3: fifo_q[rx_wr_q] <= rx_count_q[7:0]; // see R15
        default: fifo_q[rx_wr_q] <= rx_count_q[15:8]; // see R15
      endcase
      rx_wr_q <= rx_wr_q + 3'h1; // see R16
      tail_q <= tail_q - 2'h1;
    end
    else if (rx_valid && loop_on)
    begin
      if (!synced_q)
        synced_q <= rx_data == SYNC_BYTE; // see R21
      else
      begin
        fifo_q[rx_wr_q] <= rx_data; // see R1
        rx_wr_q <= rx_wr_q + 3'h1; // see R14
        rx_count_q <= rx_count_q + 16'h0001; // see R21
        rx_crc_q <= crc_step(rx_crc_q, rx_data);
        if (rx_count_q < 16'(DEST_ADDR_BYTES))
          dest_q <= {rx_data, dest_q[47:8]};
      end
    end
  end

  logic addr_match;
  assign addr_match = dest_q == station_addr || dest_q[0];

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rsr_q <= 8'h00;
      isr_q <= 8'h00;
    end
    else
    begin
      if (tail_q == 2'h1)
      begin
        rsr_q <= 8'h00;
        // a forced crc error on a matching packet also clears intact
        rsr_q[RSR_INTACT_BIT] <= !addr_match || (!crc_inhibit && rx_crc_q == CRC_RESIDUE); // see R23
        rsr_q[RSR_CRC_ERR_BIT] <= addr_match && (crc_inhibit || rx_crc_q != CRC_RESIDUE); // see R22
        rsr_q[RSR_MULTICAST_BIT] <= addr_match && dest_q[0];
      end
      if (tx_q == TX_DONE)
        isr_q[ISR_SENT_BIT] <= 1'b1; // see R20
      else if (bus_req.wr && bus_req.addr == ADDR_INT_STATUS && bus_req.wdata[ISR_SENT_BIT])
        isr_q[ISR_SENT_BIT] <= 1'b0;
    end
  end

  // fifo read port: pointer step takes four clocks; a read inside that gap
  // returns the same byte, standing in for the wait state
  logic [2:0] rd_ptr_q;
  logic [2:0] adv_cnt_q;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_ptr_q <= 3'h0;
      adv_cnt_q <= 3'h0;
    end
    else if (start_tx)
      rd_ptr_q <= 3'h0;
    else if (adv_cnt_q != 3'h0)
    begin
      adv_cnt_q <= adv_cnt_q - 3'h1;
      if (adv_cnt_q == 3'h1)
        rd_ptr_q <= rd_ptr_q + 3'h1; // see R12
    end
    else if (bus_req.rd && bus_req.addr == ADDR_FIFO && loop_on)
      adv_cnt_q <= 3'(PTR_ADVANCE_CLKS); // see R12
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      bus_rdata <= 8'h00;
    else if (bus_req.rd)
    begin
      case (bus_req.addr)
        ADDR_CONFIG: bus_rdata <= config_q;
        ADDR_PAGE: bus_rdata <= page_q;
        ADDR_COUNT_LOW: bus_rdata <= tx_left_q[7:0];
        ADDR_COUNT_HIGH: bus_rdata <= tx_left_q[15:8];
        ADDR_INT_STATUS: bus_rdata <= isr_q;
        ADDR_RX_STATUS: bus_rdata <= rsr_q;
        ADDR_FIFO: bus_rdata <= fifo_q[rd_ptr_q]; // see R4
        ADDR_LINK: bus_rdata <= {7'h00, link_ok_q};
        default: bus_rdata <= 8'h00;
      endcase
    end
    else
      bus_rdata <= 8'h00;
  end

endmodule : mac_loopback_diagnostics
`default_nettype wire

/* File: tb/mac_loopback_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mac_loopback_properties
  import mac_loopback_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire reg_req_t bus_req,
  input wire logic [7:0] bus_rdata,
  input wire mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_valid,
  input wire logic link_fail,
  input wire logic codec_loop_control,
  input wire logic cable_tx_enable,
  input wire logic collision_seen,
  input wire logic carrier_seen
);
  logic [2:0] cfg_q;
  logic [1:0] age_q;
  logic [3:0] idx_q;
  logic [1:0] loop;
  logic settled;
  assign loop = cfg_q[2:1];
  // outputs lag the config write by up to two registers
  assign settled = age_q >= 2'h2;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cfg_q <= 3'h0;
      age_q <= 2'h0;
    end
    else if (bus_req.wr && bus_req.addr == ADDR_CONFIG)
    begin
      cfg_q <= bus_req.wdata[2:0];
      age_q <= 2'h0;
    end
    else if (age_q != 2'h3)
      age_q <= age_q + 2'h1;
  end

  // byte index within the frame, restarted by each transmit command
  always_ff @(posedge clk)
  begin
    if (!rstn || (bus_req.wr && bus_req.addr == ADDR_COMMAND && bus_req.wdata[CMD_TRANSMIT_BIT]))
      idx_q <= 4'h0;
    else if (ser_tx_valid && idx_q != 4'hf)
      idx_q <= idx_q + 4'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence link_down_s;
    link_fail ##1 link_fail;
  endsequence

  sequence ext_up_s;
    (settled && loop == LOOP_EXTERNAL && !link_fail) ##1 !link_fail;
  endsequence

  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside its slot");
  a_codec_loop_sel: assert property (settled |-> codec_loop_control == (loop == LOOP_CODEC))
    else $error("codec loop control wrong");
  a_loop_masks: assert property (settled && loop != LOOP_NONE |-> !collision_seen && !carrier_seen)
    else $error("collision or carrier leaked in loopback");
  a_serial_quiet: assert property (settled && loop == LOOP_SERIAL |-> !ser_tx_valid && !cable_tx_enable)
    else $error("serial loopback left the chip");
  a_codec_cable_off: assert property (settled && loop == LOOP_CODEC |-> !cable_tx_enable)
    else $error("cable driven in codec loopback");
  a_link_fail_off: assert property (link_down_s |-> !cable_tx_enable)
    else $error("transmitter on with link failed");
  a_cable_external: assert property (ext_up_s |-> cable_tx_enable)
    else $error("cable off in external loopback");
  a_preamble_bytes: assert property (ser_tx_valid && idx_q < 4'h7 |-> ser_tx_data == PREAMBLE_BYTE)
    else $error("bad preamble byte");
  a_sync_byte: assert property (ser_tx_valid && idx_q == 4'h7 |-> ser_tx_data == SYNC_BYTE)
    else $error("bad sync byte");
  a_mem_req_hold: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr))
    else $error("memory request dropped early");
endmodule : mac_loopback_properties

bind mac_loopback_diagnostics mac_loopback_properties u_mac_loopback_properties (.clk, .rstn, .bus_req,
  .bus_rdata, .mem_req, .mem_ack, .ser_tx_data, .ser_tx_valid, .link_fail, .codec_loop_control,
  .cable_tx_enable, .collision_seen, .carrier_seen);
`default_nettype wire

/* File: tb/loop_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module loop_partner
  import mac_loopback_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] ack_delay,
  input wire mem_req_t mem_req,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  output logic [15:0] ack_count,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_valid,
  output logic [7:0] line_rx_data,
  output logic line_rx_valid,
  output logic line_rx_end
);
  logic [3:0] wait_q;
  logic [5:0] idle_q;
  logic busy_q;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wait_q <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      ack_count <= 16'h0000;
    end
    else if (mem_req.req && !mem_ack && wait_q >= ack_delay)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_req.addr[7:0] ^ 8'ha4;
      ack_count <= ack_count + 16'h0001;
      wait_q <= 4'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      // no stale data between grants
      mem_rdata <= ~mem_rdata;
      wait_q <= mem_req.req ? wait_q + 4'h1 : 4'h0;
    end
  end

  // frame end only after a long silence, so paced bytes do not split a frame
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      line_rx_valid <= 1'b0;
      line_rx_data <= 8'h00;
      line_rx_end <= 1'b0;
      idle_q <= 6'h00;
      busy_q <= 1'b0;
    end
    else
    begin
      line_rx_valid <= ser_tx_valid;
      line_rx_data <= ser_tx_valid ? ser_tx_data : ~line_rx_data;
      line_rx_end <= busy_q && idle_q == 6'h30;
      busy_q <= ser_tx_valid || (busy_q && idle_q != 6'h30);
      idle_q <= ser_tx_valid ? 6'h00 : idle_q + 6'h01;
    end
  end
endmodule : loop_partner
`default_nettype wire

/* File: tb/mac_loopback_diagnostics_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected t=%0t got %h exp %h", $time, (g), (e)); end end
module mac_loopback_diagnostics_tb_top
  import mac_loopback_pkg::*;
;
  logic clk, rstn, mem_ack, ser_tx_valid, line_rx_valid, line_rx_end, codec_collision, codec_carrier;
  logic link_fail, codec_loop_control, cable_tx_enable, collision_seen, carrier_seen;
  logic [7:0] bus_rdata, mem_rdata, ser_tx_data, line_rx_data;
  logic [47:0] station_addr;
  logic [3:0] ack_delay;
  logic [15:0] ack_count;
  reg_req_t bus_req;
  mem_req_t mem_req;
  int mismatches, n_tests;
  localparam logic [47:0] MATCH = 48'ha1a0_a7a6_a5a4;

  mac_loopback_diagnostics u_mac_loopback_diagnostics (.clk, .rstn, .bus_req, .bus_rdata, .mem_req,
    .mem_ack, .mem_rdata, .ser_tx_data, .ser_tx_valid, .line_rx_data, .line_rx_valid, .line_rx_end,
    .codec_collision, .codec_carrier, .link_fail, .station_addr, .codec_loop_control,
    .cable_tx_enable, .collision_seen, .carrier_seen);
  loop_partner u_loop_partner (.clk, .rstn, .ack_delay, .mem_req, .mem_ack, .mem_rdata, .ack_count,
    .ser_tx_data, .ser_tx_valid, .line_rx_data, .line_rx_valid, .line_rx_end);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask : rd_chk

  // 13-byte packet from page 0x40; config was left at normal before entry
  task automatic run_tx(input logic [7:0] cfg, input logic [47:0] sa, input logic [3:0] dly);
    logic [7:0] d;
    wr(ADDR_CONFIG, cfg);
    station_addr <= sa;
    ack_delay <= dly;
    wr(ADDR_PAGE, 8'h40);
    wr(ADDR_COUNT_LOW, 8'h0d);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_COMMAND, 8'h04);
    d = 8'h00;
    for (int i = 0; i < 2000 && d[ISR_SENT_BIT] !== 1'b1; i++)
      rd(ADDR_INT_STATUS, d);
    `CHK(d[ISR_SENT_BIT], 1'b1)
    repeat (100) @(posedge clk);
  endtask : run_tx

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] d2;
    bus_req = '0;
    rstn = 1'b0;
    {codec_collision, codec_carrier, link_fail} = 3'h0;
    station_addr = 48'h0000_0000_0000;
    ack_delay = 4'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(ADDR_INT_STATUS, 8'h00);
    rd_chk(4'hf, 8'h00);
    @(posedge clk);
    codec_collision <= 1'b1;
    codec_carrier <= 1'b1;
    run_tx(8'h05, MATCH, 4'h0);
    `CHK(codec_loop_control, 1'b1)
    `CHK({collision_seen, carrier_seen}, 2'b00)
    `CHK(ack_count, 16'h000d)
    rd_chk(ADDR_CONFIG, 8'h05);
    rd_chk(ADDR_PAGE, 8'h40);
    rd_chk(ADDR_COUNT_LOW, 8'h00);
    rd_chk(ADDR_COUNT_HIGH, 8'h00);
    rd_chk(ADDR_RX_STATUS, 8'h02);
    for (int i = 0; i < 8; i++)
    begin
      rd(ADDR_FIFO, d);
      `CHK(d, i < 5 ? 8'(i + 8) ^ 8'ha4 : (i == 5 ? 8'h0d : 8'h00))
      repeat (4) @(posedge clk);
    end
    // second read lands inside the pointer settling time
    rd(ADDR_FIFO, d);
    rd(ADDR_FIFO, d2);
    `CHK(d, 8'hac)
    `CHK(d2, 8'hac)
    wr(ADDR_INT_STATUS, 8'h02);
    rd_chk(ADDR_INT_STATUS, 8'h00);
    wr(ADDR_CONFIG, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    `CHK(collision_seen, 1'b1)
    `CHK(carrier_seen, 1'b1)
    run_tx(8'h03, 48'h0000_0000_0000, 4'hc);
    `CHK(cable_tx_enable, 1'b0)
    `CHK(ack_count, 16'h001a)
    rd_chk(ADDR_RX_STATUS, 8'h01);
    wr(ADDR_INT_STATUS, 8'h02);
    wr(ADDR_CONFIG, 8'h00);
    link_fail <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(cable_tx_enable, 1'b0)
    rd_chk(ADDR_LINK, 8'h00);
    @(posedge clk);
    link_fail <= 1'b0;
    // link integrity is checked before the external test
    rd_chk(ADDR_LINK, 8'h01);
    run_tx(8'h06, MATCH, 4'h2);
    `CHK(cable_tx_enable, 1'b1)
    rd_chk(ADDR_RX_STATUS, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      rd(ADDR_FIFO, d);
      if (i >= 1 && i <= 4)
        `CHK(d, i == 1 ? 8'h11 : (i == 4 ? 8'ha8 : 8'h00))
      repeat (4) @(posedge clk);
    end
    wr(ADDR_CONFIG, 8'h00);
    complete_run();
  end
endmodule : mac_loopback_diagnostics_tb_top
`default_nettype wire
